/* rtl/amp_serial_port.sv */
// amplifier end of the serial audio port: config, framing, sense output
`timescale 1ns/1ps
module amp_serial_port
   import audio_link_pkg::*;
(
   input  wire logic                                clock,
   input  wire logic                                arst_n,
   audio_link_if.device                             link,
   input  wire logic                                addr_select,
   input  wire logic                                cfg_req,
   input  wire logic                                cfg_write,
   input  wire logic [6:0]                          cfg_target,
   input  wire logic [7:0]                          cfg_addr,
   input  wire logic [7:0]                          cfg_wdata,
   output logic                                     cfg_ack,
   output logic                                     cfg_nack,
   output logic [7:0]                               cfg_rdata,
   input  wire logic [15:0]                         sense_current,
   input  wire logic [15:0]                         sense_voltage,
   input  wire logic [7:0]                          battery_level,
   input  wire logic [7:0]                          boost_rail_voltage,
   input  wire logic [4:0]                          pga_gain,
   input  wire logic                                tracking_active,
   input  wire logic                                sense_current_bit,
   input  wire logic                                sense_voltage_bit,
   output logic                                     analog_path,
   output logic                                     density_input_select,
   output logic                                     density_bit,
   output logic [15:0]                              mod_pcm,
   output logic [audio_link_pkg::RATE_HZ_W-1:0]     sample_rate_hz
);
   import audio_link_pkg::*;

   typedef struct packed {
      logic [7:0]  in_cfg;
      logic [7:0]  idle_cfg;
      logic [7:0]  fmt_cfg;
      logic [7:0]  ofs_cfg;
      logic [7:0]  osel_cfg;
      logic [1:0]  bclk_sy;
      logic [1:0]  wclk_sy;
      logic [1:0]  din_sy;
      logic [1:0]  asel_sy;
      logic        bclk_prev;
      logic        wclk_prev;
      logic [7:0]  div;
      logic        bclk_gen;
      logic        wclk_gen;
      logic [8:0]  pos;
      logic [31:0] tx_sh;
      logic [5:0]  tx_left;
      logic        tx_hiz;
      logic        dout;
      logic        dout_oe_n;
      logic [15:0] rx_sh;
      logic [15:0] rx_l;
      logic [15:0] rx_r;
      logic [15:0] pcm;
      logic        ack;
      logic        nack;
      logic [7:0]  rdata;
   } dev_s;

   localparam dev_s DEV_RST = '{in_cfg: IN_CFG_RST, idle_cfg: IDLE_RST, fmt_cfg: FMT_RST,
                                ofs_cfg: OFS_RST, osel_cfg: OSEL_RST, dout_oe_n: 1'b1,
                                default: '0};

   // sense source word, left aligned; zeros fill the tail
   function automatic logic [31:0] src_word(input logic [2:0] src, input logic valid);
      logic [7:0] bat;
      logic [7:0] bst;
      bat = valid ? battery_level : 8'h00;
      bst = valid ? boost_rail_voltage : 8'h00;
      case (src)
         3'b000:  return {sense_current, 16'h0000};
         3'b001:  return {sense_voltage, 16'h0000};
         3'b010:  return {bat, 24'h000000};
         3'b011:  return {bst, 24'h000000};
         3'b100:  return {pga_gain, 27'h0000000};
         3'b101:  return {sense_current, sense_voltage};
         3'b110:  return {bat, bst, pga_gain, 11'h000};
         default: return 32'h00000000;
      endcase
   endfunction

   function automatic logic [RATE_HZ_W-1:0] rate_hz(input logic [2:0] code);
      case (code)
         3'b000:  return 18'h01F40;
         3'b001:  return 18'h02EE0;
         3'b010:  return 18'h03E80;
         3'b011:  return 18'h05DC0;
         3'b100:  return 18'h07D00;
         3'b101:  return 18'h0BB80;
         3'b110:  return 18'h17700;
         default: return 18'h2EE00;
      endcase
   endfunction

   dev_s        q;
   dev_s        d;
   logic        bl;
   logic        wl;
   logic        rise;
   logic        fall;
   logic        start;
   logic        pcm_out;
   logic [1:0]  fmt;
   logic [1:0]  dsel;
   logic [2:0]  src;
   logic [8:0]  fb;
   logic [5:0]  wb;
   logic [8:0]  nxt;
   logic [8:0]  pr;
   logic [8:0]  ls;
   logic [8:0]  rs;
   logic [31:0] w;
   logic [5:0]  n;
   logic        hz;
   logic [16:0] sum;

   always_comb begin
      d = q;
      d.ack = 1'b0;
      d.nack = 1'b0;
      d.bclk_sy = {q.bclk_sy[0], link.bclk};
      d.wclk_sy = {q.wclk_sy[0], link.wclk};
      d.din_sy = {q.din_sy[0], link.din};
      d.asel_sy = {q.asel_sy[0], addr_select};
      fmt = q.fmt_cfg[FFMT_LSB +: 2];
      dsel = q.osel_cfg[DSEL_LSB +: 2];
      pcm_out = q.in_cfg[OUT_FMT_BIT];
      bl = q.fmt_cfg[BCLK_DIR_BIT] ? q.bclk_gen : q.bclk_sy[1];
      wl = q.fmt_cfg[FCLK_DIR_BIT] ? q.wclk_gen : q.wclk_sy[1];
      rise = bl & !q.bclk_prev;
      fall = !bl & q.bclk_prev;
      d.bclk_prev = bl;
      if (q.div == BCLK_HALF_CYCLES - 8'h01) begin
         d.div = 8'h00;
         d.bclk_gen = !q.bclk_gen;
      end else begin
         d.div = q.div + 8'h01;
      end
      fb = frame_bits(q.fmt_cfg[FLEN_LSB +: 2]);
      wb = word_bits(q.fmt_cfg[1:0]);
      nxt = (q.pos + 9'h001 >= fb) ? 9'h000 : q.pos + 9'h001;
      start = (fmt == FMT_I2S) ? (q.wclk_prev & !wl) : (!q.wclk_prev & wl);
      pr = start ? 9'h000 : nxt;
      ls = slot_start(fmt, q.ofs_cfg, fb, wb, 1'b0);
      rs = slot_start(fmt, q.ofs_cfg, fb, wb, 1'b1);
      src = (nxt == ls) ? q.osel_cfg[2:0] : q.osel_cfg[RSRC_LSB +: 3];
      w = q.tx_sh;
      n = q.tx_left;
      hz = q.tx_hiz;
      sum = {q.rx_l[15], q.rx_l} + {q.rx_r[15], q.rx_r};
      if (fall) begin
         d.wclk_gen = wclk_level(fmt, nxt, fb);
         if (pcm_out) begin
            if (nxt == ls || nxt == rs) begin
               w = src_word(src, tracking_active);
               n = wb;
               hz = (src == 3'b111);
            end
            if (n != 6'h00) begin
               d.dout = w[31];
               d.dout_oe_n = hz;
               d.tx_sh = {w[30:0], 1'b0};
               d.tx_left = n - 6'h01;
               d.tx_hiz = hz;
            end else begin
               d.dout = 1'b0;
               d.dout_oe_n = q.idle_cfg[IDLE_HIZ_BIT];
            end
         end else begin
            // first half of clock edge choice
            d.dout = dsel[0] ? sense_voltage_bit : sense_current_bit;
            d.dout_oe_n = !(dsel[1] | !q.osel_cfg[RSRC_LSB + 2]);
         end
      end
      if (rise) begin
         d.pos = pr;
         d.wclk_prev = wl;
         if (pr - ls < 9'(SAMPLE_W) || pr - rs < 9'(SAMPLE_W)) begin
            d.rx_sh = {q.rx_sh[14:0], q.din_sy[1]};
         end
         if (pr == ls + 9'(SAMPLE_W - 1)) d.rx_l = {q.rx_sh[14:0], q.din_sy[1]};
         if (pr == rs + 9'(SAMPLE_W - 1)) d.rx_r = {q.rx_sh[14:0], q.din_sy[1]};
         if (!pcm_out) begin
            // density output second half edge choice
            d.dout = (dsel[0] ^ dsel[1]) ? sense_voltage_bit : sense_current_bit;
            d.dout_oe_n = !(dsel[1] | q.osel_cfg[RSRC_LSB + 2]);
         end
      end
      // modulator channel select analog path silences it
      case (q.in_cfg[CH_SEL_LSB +: 2])
         2'b00:   d.pcm = 16'h0000;
         2'b01:   d.pcm = q.rx_l;
         2'b10:   d.pcm = q.rx_r;
         default: d.pcm = sum[16:1];
      endcase
      if (q.in_cfg[IN_ANALOG_BIT] || q.in_cfg[PDM_IN_BIT]) d.pcm = 16'h0000;
      if (cfg_req) begin
         if (cfg_target == (DEV_ADDR_BASE | {6'h00, q.asel_sy[1]})) begin
            d.ack = 1'b1;
            case (cfg_addr)
               REG_IN_CFG: begin
                  d.rdata = q.in_cfg;
                  if (cfg_write) d.in_cfg = cfg_wdata;
               end
               REG_IDLE: begin
                  d.rdata = q.idle_cfg;
                  if (cfg_write) d.idle_cfg = cfg_wdata;
               end
               REG_FMT: begin
                  d.rdata = q.fmt_cfg;
                  if (cfg_write) d.fmt_cfg = cfg_wdata;
               end
               REG_OFS: begin
                  d.rdata = q.ofs_cfg;
                  if (cfg_write) d.ofs_cfg = cfg_wdata;
               end
               REG_OSEL: begin
                  d.rdata = q.osel_cfg;
                  if (cfg_write) d.osel_cfg = cfg_wdata;
               end
               default: d.rdata = 8'h00;
            endcase
         end else begin
            d.nack = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         q <= DEV_RST;
      end else begin
         q <= d;
      end
   end

   assign link.bclk_dev = q.bclk_gen;
   assign link.bclk_dev_oe_n = !q.fmt_cfg[BCLK_DIR_BIT];
   assign link.wclk_dev = q.wclk_gen;
   assign link.wclk_dev_oe_n = !q.fmt_cfg[FCLK_DIR_BIT];
   assign link.dout_o = q.dout;
   assign link.dout_oe_n = q.dout_oe_n;
   assign cfg_ack = q.ack;
   assign cfg_nack = q.nack;
   assign cfg_rdata = q.rdata;
   assign analog_path = q.in_cfg[IN_ANALOG_BIT];
   // density only on digital path; the analog pins are the system's job
   assign density_input_select = !q.in_cfg[IN_ANALOG_BIT] & q.in_cfg[PDM_IN_BIT];
   assign density_bit = q.din_sy[1];
   assign mod_pcm = q.pcm;
   assign sample_rate_hz = rate_hz(q.in_cfg[2:0]);
endmodule // amp_serial_port

/* rtl/audio_link_pkg.sv */
// shared constants, types and framing helpers for the serial audio link
package audio_link_pkg;
   // device register offsets and values after reset
   localparam logic [7:0] REG_IN_CFG   = 8'h03;
   localparam logic [7:0] REG_IDLE     = 8'h04;
   localparam logic [7:0] REG_FMT      = 8'h05;
   localparam logic [7:0] REG_OFS      = 8'h06;
   localparam logic [7:0] REG_OSEL     = 8'h07;
   localparam logic [7:0] IN_CFG_RST   = 8'h80;
   localparam logic [7:0] IDLE_RST     = 8'h00;
   localparam logic [7:0] FMT_RST      = 8'h00;
   localparam logic [7:0] OFS_RST      = 8'h00;
   localparam logic [7:0] OSEL_RST     = 8'hC0;
   localparam logic [6:0] DEV_ADDR_BASE = 7'h40;
   // field positions
   localparam int IN_ANALOG_BIT = 7;
   localparam int OUT_FMT_BIT   = 6;
   localparam int PDM_IN_BIT    = 5;
   localparam int CH_SEL_LSB    = 3;
   localparam int IDLE_HIZ_BIT  = 2;
   localparam int FCLK_DIR_BIT  = 7;
   localparam int BCLK_DIR_BIT  = 6;
   localparam int FLEN_LSB      = 4;
   localparam int FFMT_LSB      = 2;
   localparam int DSEL_LSB      = 6;
   localparam int RSRC_LSB      = 3;
   localparam int SAMPLE_W      = 16;
   localparam int RATE_HZ_W     = 18;
   // half period of a generated bit clock, in clock cycles
   localparam logic [7:0] BCLK_HALF_CYCLES = 8'h08;
   // host register byte addresses
   localparam logic [7:0] H_CTRL   = 8'h00;
   localparam logic [7:0] H_TXL    = 8'h04;
   localparam logic [7:0] H_TXR    = 8'h08;
   localparam logic [7:0] H_RXL    = 8'h0C;
   localparam logic [7:0] H_RXR    = 8'h10;
   localparam logic [7:0] H_STAT   = 8'h14;
   localparam logic [16:0] H_CTRL_RST = 17'h00000;

   typedef enum logic [1:0] {
      FMT_I2S = 2'b00,
      FMT_DSP = 2'b01,
      FMT_RJ  = 2'b10,
      FMT_LJ  = 2'b11
   } frame_format_code_e;

   function automatic logic [8:0] frame_bits(input logic [1:0] code);
      return 9'h020 << code;
   endfunction

   function automatic logic [5:0] word_bits(input logic [1:0] code);
      case (code)
         2'b00:   return 6'h10;
         2'b01:   return 6'h14;
         2'b10:   return 6'h18;
         default: return 6'h20;
      endcase
   endfunction

   // frame index of a slot's msb
   function automatic logic [8:0] slot_start(input logic [1:0] fmt, input logic [7:0] ofs,
                                             input logic [8:0] fb, input logic [5:0] wb,
                                             input logic right);
      logic [8:0] s;
      s = {1'b0, ofs};
      if (fmt == FMT_I2S) s = s + 9'h001;
      if (fmt == FMT_RJ) s = s + (fb >> 1) - {3'h0, wb};
      if (right) s = s + ((fmt == FMT_DSP) ? {3'h0, wb} : (fb >> 1));
      return s;
   endfunction

   // level of the word clock for the bit that takes frame index p
   function automatic logic wclk_level(input logic [1:0] fmt, input logic [8:0] p,
                                       input logic [8:0] fb);
      case (fmt)
         FMT_I2S: return p >= (fb >> 1);
         FMT_DSP: return p == 9'h000;
         default: return p < (fb >> 1);
      endcase
   endfunction
endpackage

/* rtl/audio_link_if.sv */
// serial audio link pins between amplifier port and host port
`timescale 1ns/1ps
interface audio_link_if;
   logic bclk_dev;
   logic bclk_dev_oe_n;
   logic bclk_host;
   logic bclk_host_oe_n;
   logic wclk_dev;
   logic wclk_dev_oe_n;
   logic wclk_host;
   logic wclk_host_oe_n;
   logic din;
   logic dout_o;
   logic dout_oe_n;
   logic bclk;
   logic wclk;
   logic dout;
   logic dout_driven;

   // undriven wires read low (weak pull-down)
   assign bclk = !bclk_dev_oe_n ? bclk_dev : (!bclk_host_oe_n ? bclk_host : 1'b0);
   assign wclk = !wclk_dev_oe_n ? wclk_dev : (!wclk_host_oe_n ? wclk_host : 1'b0);
   assign dout = !dout_oe_n ? dout_o : 1'b0;
   assign dout_driven = !dout_oe_n;

   modport device (output bclk_dev, bclk_dev_oe_n, wclk_dev, wclk_dev_oe_n, dout_o, dout_oe_n,
                   input bclk, wclk, din);
   modport host (output bclk_host, bclk_host_oe_n, wclk_host, wclk_host_oe_n, din,
                 input bclk, wclk, dout);
endinterface

/* rtl/host_serial_port.sv */
// host end of the serial audio port, steered over apb
`timescale 1ns/1ps
module host_serial_port
   import audio_link_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          arst_n,
   audio_link_if.host         link,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   output logic               analog_quiet
);
   import audio_link_pkg::*;

   typedef struct packed {
      logic [16:0] ctrl;
      logic [31:0] txl;
      logic [31:0] txr;
      logic [31:0] rxl;
      logic [31:0] rxr;
      logic [15:0] frames;
      logic [31:0] rdata;
      logic [1:0]  bclk_sy;
      logic [1:0]  wclk_sy;
      logic [1:0]  dout_sy;
      logic        bclk_prev;
      logic        wclk_prev;
      logic [7:0]  div;
      logic        bclk_gen;
      logic        wclk_gen;
      logic [8:0]  pos;
      logic [31:0] tx_sh;
      logic [5:0]  tx_left;
      logic        din;
      logic [31:0] rx_sh;
   } host_s;

   localparam host_s HOST_RST = '{ctrl: H_CTRL_RST, default: '0};

   host_s       q;
   host_s       d;
   logic        bl;
   logic        wl;
   logic        rise;
   logic        fall;
   logic        start;
   logic [1:0]  fmt;
   logic [8:0]  fb;
   logic [5:0]  wb;
   logic [8:0]  nxt;
   logic [8:0]  pr;
   logic [8:0]  ls;
   logic [8:0]  rs;
   logic [31:0] rxw;
   logic        mapped;

   always_comb begin
      d = q;
      d.bclk_sy = {q.bclk_sy[0], link.bclk};
      d.wclk_sy = {q.wclk_sy[0], link.wclk};
      d.dout_sy = {q.dout_sy[0], link.dout};
      fmt = q.ctrl[5:4];
      // drive whichever clock the amplifier takes as input
      bl = q.ctrl[0] ? q.bclk_gen : q.bclk_sy[1];
      wl = q.ctrl[1] ? q.wclk_gen : q.wclk_sy[1];
      rise = bl & !q.bclk_prev;
      fall = !bl & q.bclk_prev;
      d.bclk_prev = bl;
      if (q.div == BCLK_HALF_CYCLES - 8'h01) begin
         d.div = 8'h00;
         d.bclk_gen = !q.bclk_gen;
      end else begin
         d.div = q.div + 8'h01;
      end
      fb = frame_bits(q.ctrl[3:2]);
      wb = word_bits(q.ctrl[7:6]);
      nxt = (q.pos + 9'h001 >= fb) ? 9'h000 : q.pos + 9'h001;
      start = (fmt == FMT_I2S) ? (q.wclk_prev & !wl) : (!q.wclk_prev & wl);
      pr = start ? 9'h000 : nxt;
      ls = slot_start(fmt, q.ctrl[15:8], fb, wb, 1'b0);
      rs = slot_start(fmt, q.ctrl[15:8], fb, wb, 1'b1);
      rxw = {q.rx_sh[30:0], q.dout_sy[1]} << (6'h20 - wb);
      if (fall) begin
         d.wclk_gen = wclk_level(fmt, nxt, fb);
         if (nxt == ls || nxt == rs) begin
            d.din = (nxt == ls) ? q.txl[31] : q.txr[31];
            d.tx_sh = {((nxt == ls) ? q.txl[30:0] : q.txr[30:0]), 1'b0};
            d.tx_left = wb - 6'h01;
         end else if (q.tx_left != 6'h00) begin
            d.din = q.tx_sh[31];
            d.tx_sh = {q.tx_sh[30:0], 1'b0};
            d.tx_left = q.tx_left - 6'h01;
         end else begin
            d.din = 1'b0;
         end
      end
      if (rise) begin
         d.pos = pr;
         d.wclk_prev = wl;
         d.rx_sh = {q.rx_sh[30:0], q.dout_sy[1]};
         if (start) d.frames = q.frames + 16'h0001;
         if (pr == ls + {3'h0, wb} - 9'h001) d.rxl = rxw;
         if (pr == rs + {3'h0, wb} - 9'h001) d.rxr = rxw;
      end
      mapped = 1'b1;
      case (paddr)
         H_CTRL: d.rdata = {15'h0000, q.ctrl};
         H_TXL:  d.rdata = q.txl;
         H_TXR:  d.rdata = q.txr;
         H_RXL:  d.rdata = q.rxl;
         H_RXR:  d.rdata = q.rxr;
         H_STAT: d.rdata = {16'h0000, q.frames};
         default: begin
            d.rdata = 32'h00000000;
            mapped = 1'b0;
         end
      endcase
      // read data settles in setup, so access always completes at once
      if (!(psel && !penable)) d.rdata = q.rdata;
      if (psel && penable && pwrite) begin
         case (paddr)
            H_CTRL:  d.ctrl = pwdata[16:0];
            H_TXL:   d.txl = pwdata;
            H_TXR:   d.txr = pwdata;
            default: d.ctrl = q.ctrl;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         q <= HOST_RST;
      end else begin
         q <= d;
      end
   end

   assign link.bclk_host = q.bclk_gen;
   assign link.bclk_host_oe_n = !q.ctrl[0];
   assign link.wclk_host = q.wclk_gen;
   assign link.wclk_host_oe_n = !q.ctrl[1];
   assign link.din = q.din;
   assign prdata = q.rdata;
   assign pready = 1'b1;
   assign pslverr = psel & penable & !mapped;
   // software holds the analog input quiet on digital path
   assign analog_quiet = q.ctrl[16];
endmodule // host_serial_port

/* verif/audio_serial_port_config_chk.sv */
// link checker: generated clocks and pin directions
`timescale 1ns/1ps
module audio_serial_port_config_chk (
   input wire logic clock, arst_n, bclk, bclk_dev, bclk_dev_oe_n, bclk_host,
   input wire logic bclk_host_oe_n, wclk_dev, wclk_dev_oe_n, wclk_host,
   input wire logic wclk_host_oe_n, din
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // half period of 8 clocks, then a toggle
   sequence s_half_h;
      (bclk_host_oe_n || $stable(bclk_host)) [*7] ##1 (bclk_host_oe_n || $changed(bclk_host));
   endsequence
   sequence s_half_d;
      (bclk_dev_oe_n || $stable(bclk_dev)) [*7] ##1 (bclk_dev_oe_n || $changed(bclk_dev));
   endsequence
   property p_half_h;
      $changed(bclk_host) && !bclk_host_oe_n |=> s_half_h;
   endproperty
   property p_half_d;
      $changed(bclk_dev) && !bclk_dev_oe_n |=> s_half_d;
   endproperty
   property p_bclk_one;
      bclk_dev_oe_n || bclk_host_oe_n;
   endproperty
   property p_wclk_one;
      wclk_dev_oe_n || wclk_host_oe_n;
   endproperty
   // frame clock moves only while bit clock is low
   property p_hwclk_edge;
      $changed(wclk_host) && !wclk_host_oe_n && $past(!wclk_host_oe_n) |-> !bclk_host;
   endproperty
   property p_dwclk_edge;
      $changed(wclk_dev) && !wclk_dev_oe_n && $past(!wclk_dev_oe_n) |-> !bclk_dev;
   endproperty
   // a frame clock level holds at least 8 clocks after a change, half a bit clock
   property p_hwclk_hold;
      $changed(wclk_host) && !wclk_host_oe_n |=> (wclk_host_oe_n || $stable(wclk_host)) [*8];
   endproperty
   property p_dwclk_hold;
      $changed(wclk_dev) && !wclk_dev_oe_n |=> (wclk_dev_oe_n || $stable(wclk_dev)) [*8];
   endproperty
   property p_din_edge;
      $changed(din) && $past(arst_n) |-> !bclk;
   endproperty
   a_half_h: assert property (p_half_h) else $error("host bit clock half period wrong");
   a_half_d: assert property (p_half_d) else $error("amp bit clock half period wrong");
   a_bclk_one: assert property (p_bclk_one) else $error("bit clock driven twice");
   a_wclk_one: assert property (p_wclk_one) else $error("frame clock driven twice");
   a_hwclk_edge: assert property (p_hwclk_edge) else $error("host frame edge");
   a_dwclk_edge: assert property (p_dwclk_edge) else $error("amp frame edge");
   a_hwclk_hold: assert property (p_hwclk_hold) else $error("host frame too short");
   a_dwclk_hold: assert property (p_dwclk_hold) else $error("amp frame too short");
   a_din_edge: assert property (p_din_edge) else $error("data moved on rising");
endmodule // audio_serial_port_config_chk

/* verif/audio_serial_port_config_tb_top.sv */
// self-checking bench joining both ends of the serial audio link
`timescale 1ns/1ps
module audio_serial_port_config_tb_top;
   import audio_link_pkg::*;
   logic clock = 1'b0, arst_n = 1'b0, asel = 1'b0, creq = 1'b0, cwr = 1'b0, cack, cnack;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, aq, ap, dis, trk = 1'b1;
   logic [6:0] ctgt = 7'h00;
   logic [7:0] cadr = 8'h00, cwd = 8'h00, paddr = 8'h00, crd;
   logic [15:0] sc = 16'hC3A5, sv = 16'h5A3C, mpcm;
   logic [17:0] rate;
   logic [31:0] pwdata = 32'h0, prdata, r;
   int fail_count = 0, checks = 0, k;
   audio_link_if link ();
   amp_serial_port i_amp_serial_port (.clock(clock), .arst_n(arst_n), .link(link),
      .addr_select(asel), .cfg_req(creq), .cfg_write(cwr), .cfg_target(ctgt), .cfg_addr(cadr),
      .cfg_wdata(cwd), .cfg_ack(cack), .cfg_nack(cnack), .cfg_rdata(crd), .sense_current(sc),
      .sense_voltage(sv), .battery_level(8'h5C), .boost_rail_voltage(8'hA3), .pga_gain(5'h11),
      .tracking_active(trk), .sense_current_bit(sc[15]), .sense_voltage_bit(1'b1),
      .analog_path(ap), .density_input_select(dis), .density_bit(), .mod_pcm(mpcm),
      .sample_rate_hz(rate));
   host_serial_port i_host_serial_port (.clock(clock), .arst_n(arst_n), .link(link),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog_quiet(aq));
   audio_serial_port_config_chk i_audio_serial_port_config_chk (.clock(clock), .arst_n(arst_n),
      .bclk(link.bclk), .bclk_dev(link.bclk_dev), .bclk_dev_oe_n(link.bclk_dev_oe_n),
      .bclk_host(link.bclk_host), .bclk_host_oe_n(link.bclk_host_oe_n),
      .wclk_dev(link.wclk_dev), .wclk_dev_oe_n(link.wclk_dev_oe_n),
      .wclk_host(link.wclk_host), .wclk_host_oe_n(link.wclk_host_oe_n), .din(link.din));
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, s);
      checks++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   // one access; only the matching target is answered with ack
   task automatic cfg(input logic [6:0] t, input logic w, input logic [7:0] a, d, e);
      logic m;
      m = (t == {6'h20, asel});
      @(posedge clock);
      creq <= 1'b1;
      cwr <= w;
      ctgt <= t;
      cadr <= a;
      cwd <= d;
      @(posedge clock);
      creq <= 1'b0;
      @(negedge clock);
      chk("cfg answer", {30'h0, m, !m}, {30'h0, cack, cnack});
      if (!w && m)
         chk("cfg rdata", {24'h0, e}, {24'h0, crd});
   endtask
   task automatic dw(input logic [7:0] a, d);
      cfg(7'h40, 1'b1, a, d, 8'h00);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic hw(input logic [7:0] a, input logic [31:0] d);
      logic e;
      apb(1'b1, a, d, e);
   endtask
   // host frame counter paces the link tests
   task automatic frames(input int n);
      logic e;
      logic [15:0] s0;
      apb(1'b0, H_STAT, 32'h0, e);
      s0 = r[15:0];
      do apb(1'b0, H_STAT, 32'h0, e); while (16'(r[15:0] - s0) < n);
   endtask
   task automatic idle_count();
      k = 0;
      repeat (2048) begin
         @(negedge clock);
         k += int'(!link.dout_driven);
      end
   endtask
   initial forever #2.5 clock = ~clock;
   initial begin
      repeat (60000) @(posedge clock);
      fail_count++;
      final_report();
   end
   initial begin : main
      logic e;
      static logic [7:0] rst [5] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'hC0};
      static int rates [8] = '{8000, 12000, 16000, 24000, 32000, 48000, 96000, 192000};
      // silence, left, right, then sum of left and right halved and truncated
      static logic [15:0] mix [4] = '{16'h0000, 16'h1234, 16'h0100, 16'h099A};
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      for (int i = 0; i < 5; i++) cfg(7'h40, 1'b0, REG_IN_CFG + 8'(i), 8'h00, rst[i]);
      cfg(7'h40, 1'b0, 8'h08, 8'h00, 8'h00);
      cfg(7'h41, 1'b1, REG_OFS, 8'h5A, 8'h00);
      apb(1'b0, 8'h18, 32'h0, e);
      chk("apb error", 32'h1, {31'h0, e});
      hw(H_CTRL, 32'h10000);
      @(negedge clock);
      chk("analog quiet", 32'h1, {31'h0, aq});
      @(posedge clock);
      asel <= 1'b1;
      repeat (3) @(posedge clock);
      cfg(7'h41, 1'b1, REG_OFS, 8'hFF, 8'h00);
      cfg(7'h40, 1'b1, REG_OFS, 8'h00, 8'h00);
      cfg(7'h41, 1'b0, REG_OFS, 8'h00, 8'hFF);
      @(posedge clock);
      asel <= 1'b0;
      repeat (3) @(posedge clock);
      $display("test registers done");
      for (int c = 0; c < 8; c++) begin
         dw(REG_IN_CFG, 8'h80 | 8'(c));
         chk("rate", 32'(rates[c]), 32'(rate));
         chk("path", 32'h2, {30'h0, ap, dis});
      end
      dw(REG_IN_CFG, 8'h20);
      chk("path", 32'h1, {30'h0, ap, dis});
      $display("test modes done");
      // host sends from bit 31 down, so samples sit left aligned
      hw(H_TXL, 32'h12340000);
      hw(H_TXR, 32'h01000000);
      hw(H_CTRL, 32'h33);
      dw(REG_OFS, 8'h00);
      dw(REG_FMT, 8'h0C);
      dw(REG_OSEL, 8'h08);
      for (int c = 0; c < 4; c++) begin
         dw(REG_IN_CFG, 8'h40 | 8'(c << 3));
         frames(3);
         chk("modulator", {16'h0, mix[c]}, {16'h0, mpcm});
      end
      apb(1'b0, H_RXL, 32'h0, e);
      chk("left rx", {sc, 16'h0}, r);
      apb(1'b0, H_RXR, 32'h0, e);
      chk("right rx", {sv, 16'h0}, r);
      $display("test stream done");
      hw(H_CTRL, 32'h37);
      dw(REG_FMT, 8'h1C);
      frames(2);
      idle_count();
      chk("undriven", 32'h0, 32'(k));
      dw(REG_IDLE, 8'h04);
      idle_count();
      chk("hiz tail", 32'h1, {31'h0, k > 0});
      dw(REG_IDLE, 8'h00);
      dw(REG_OSEL, 8'h0F);
      idle_count();
      chk("hiz slot", 32'h1, {31'h0, k > 0});
      dw(REG_OSEL, 8'h08);
      hw(H_CTRL, 32'hB7);
      dw(REG_FMT, 8'h1E);
      frames(3);
      apb(1'b0, H_RXL, 32'h0, e);
      chk("zero fill", {sc, 16'h0}, r);
      hw(H_CTRL, 32'h07);
      dw(REG_FMT, 8'h10);
      dw(REG_OSEL, 8'h0A);
      frames(3);
      apb(1'b0, H_RXL, 32'h0, e);
      chk("i2s left", 32'h5C000000, r);
      trk <= 1'b0;
      frames(3);
      apb(1'b0, H_RXL, 32'h0, e);
      chk("battery gated", 32'h0, r);
      dw(REG_OSEL, 8'h08);
      $display("test idle done");
      // host lets go first, so the clocks never have two drivers
      hw(H_CTRL, 32'hB4);
      dw(REG_FMT, 8'hDE);
      frames(3);
      chk("clock dirs", 32'h3, {28'h0, link.bclk_dev_oe_n, link.wclk_dev_oe_n,
          link.bclk_host_oe_n, link.wclk_host_oe_n});
      apb(1'b0, H_RXL, 32'h0, e);
      chk("amp clocked rx", {sc, 16'h0}, r);
      $display("test clock direction done");
      // sources first, so the line is never released while switching
      dw(REG_OSEL, 8'h80);
      dw(REG_IN_CFG, 8'h18);
      idle_count();
      chk("density pair", 32'h0, 32'(k));
      dw(REG_OSEL, 8'h00);
      idle_count();
      chk("density single", 32'h1, {31'h0, k > 0 && k < 2048});
      $display("test density done");
      final_report();
   end
endmodule // audio_serial_port_config_tb_top
